// file: rrc_defines.svh
// Constants for the reset and retention controller
`ifndef RRC_DEFINES_SVH
`define RRC_DEFINES_SVH
`define RRC_SYNC_STAGES 2
`define RRC_PULSE_CYCLES 4'h4
`define RRC_SLEEP_EXIT_CYCLES 4'h2
`endif

// file: rrc_pkg.sv
// Types for the reset and retention controller
package rrc_pkg;
    typedef enum logic [2:0] {
        RRC_EV_NONE,
        RRC_EV_POR,
        RRC_EV_HW,
        RRC_EV_SW,
        RRC_EV_SLEEP
    } rrc_event_t;
    typedef enum {
        RRC_ST_RUN,
        RRC_ST_RESET,
        RRC_ST_SLEEP
    } rrc_state_t;
endpackage : rrc_pkg

// file: rrc_sync.sv
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module rrc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule : rrc_sync

// file: rrc_reset_ctrl.sv
// Reset and retention controller: decides which storage groups clear per event
// Functional notes
// - Power-on reset while analog or primary I/O supply monitor reports low.
// - Hardware reset acts while the reset pin is held at logic 0.
// - Any write to register zero starts a software reset.
// - Sleep when regulator bit and regulator pin are both de-asserted.
// - Power-on clears all; hardware/software reset keeps sequencer, firmware configurable.
// - Sleep keeps always-on and sequencer, clears other registers and firmware.
// - Firmware kept over hardware/software reset only if core supply stays good.
`timescale 1ns/1ps
`include "rrc_defines.svh"
module rrc_reset_ctrl
    import rrc_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic analog_supply_low,
    input wire logic primary_io_supply_low,
    input wire logic core_supply_low,
    input wire logic reset_pin_n,
    input wire logic core_regulator_enable_pin,
    input wire logic core_regulator_enable_bit,
    input wire logic reg_write,
    input wire logic [15:0] reg_write_addr,
    input wire logic fw_retain_cfg,
    output logic clear_always_on,
    output logic clear_other_regs,
    output logic clear_sequencer_mem,
    output logic clear_fw_mem,
    output logic core_regulator_on,
    output logic sleep_active,
    output rrc_event_t last_event
);
    // Overview of the clear outputs
    // Each output is an active-high clear for one storage group in the core.
    // Downstream blocks hold their group in reset while the clear stands.
    // Power-on: all four groups cleared, held while either monitor reads low.
    // Hardware or software reset: always-on and ordinary registers cleared.
    // The sequencer memory is never cleared by these two events.
    // Firmware memory follows the retention setting and the core monitor.
    // Sleep: ordinary registers and firmware cleared for the whole of sleep.
    // Sleep leaves the always-on registers and sequencer memory untouched.
    //
    // Priority
    // Power-on beats hardware reset, which beats software reset, which
    // beats sleep. A software write arriving while a higher event stands is
    // swallowed; a held reset pin or sleep request is acted on once it ends.
    //
    // Timing
    // Pin-level inputs see two synchroniser stages and one state register,
    // so a pin change shows at the registered outputs on the third rising edge.
    // A register write shows on the first edge after the strobe.
    // Every reset clear is stretched for a fixed count after its cause
    // goes away, so short glitches still give a full-width clear.
    // Leaving sleep gives a short settle count with no new clear pulse.
    //
    // Limitations
    // Supply monitors are trusted as clean levels; no filtering is done
    // here, so a chattering monitor restarts the stretch every time.
    // The software reset looks at the address only; the data is ignored.
    // The core monitor matters only for the firmware retention decision.
    // A reset that ends while the regulator is off drops straight into
    // sleep, so the ordinary registers never see a gap between the two.
    // Sleep is left when the regulator comes back on or a power-on, hardware or software reset arrives.
    logic [4:0] pin_raw;
    logic [4:0] pin_sync;
    logic por_req;
    logic hw_req;
    logic sw_req;
    logic sleep_req;
    logic regulator_on;
    logic analog_low_s;
    logic io_low_s;
    logic core_low_s;
    logic reset_pin_n_s;
    logic reg_pin_s;

    // Pins come from outside the clock domain; idle values are the safe ones
    assign pin_raw = {analog_supply_low, primary_io_supply_low, core_supply_low,
                      reset_pin_n, core_regulator_enable_pin};
    // Reset view: supplies good, reset pin high, regulator pin low
    rrc_sync #(
        .WIDTH(5),
        .RESET_VAL(5'h02)
    ) u_pin_sync (
        .core_clk(core_clk),
        .resetn(resetn),
        .async_in(pin_raw),
        .sync_out(pin_sync)
    );

    // Event decode from synchronised levels
    // Named views of the synchronised pins; bit order follows pin_raw
    // Keeping the names here avoids index slips in the decode below
    assign analog_low_s = pin_sync[4];
    assign io_low_s = pin_sync[3];
    assign core_low_s = pin_sync[2];
    assign reset_pin_n_s = pin_sync[1];
    assign reg_pin_s = pin_sync[0];
    assign por_req = analog_low_s | io_low_s;
    assign hw_req = ~reset_pin_n_s;
    // Address alone triggers; data is never looked at
    assign sw_req = reg_write && (reg_write_addr == 16'h0000);
    // Regulator runs if either control asks for it
    assign regulator_on = core_regulator_enable_bit | reg_pin_s;
    assign sleep_req = ~regulator_on;

    rrc_state_t state_q, state_d;
    rrc_event_t event_q, event_d;
    logic [3:0] cnt_q, cnt_d;
    logic ao_q, ao_d;
    logic oth_q, oth_d;
    logic seq_q, seq_d;
    logic fw_q, fw_d;

    // Next state: priority POR > hardware > software > sleep
    always_comb begin
        state_d = state_q;
        event_d = event_q;
        cnt_d = cnt_q;
        ao_d = 1'b0;
        oth_d = 1'b0;
        seq_d = 1'b0;
        fw_d = 1'b0;
        if (por_req) begin
            // Power-on: every group cleared, held while supply is low
            state_d = RRC_ST_RESET;
            event_d = RRC_EV_POR;
            cnt_d = `RRC_PULSE_CYCLES;
            ao_d = 1'b1;
            oth_d = 1'b1;
            seq_d = 1'b1;
            fw_d = 1'b1;
        end else if (hw_req || sw_req) begin
            state_d = RRC_ST_RESET;
            event_d = hw_req ? RRC_EV_HW : RRC_EV_SW;
            cnt_d = `RRC_PULSE_CYCLES;
            ao_d = 1'b1;
            oth_d = 1'b1;
            // Firmware kept only if configured and core supply held up
            fw_d = ~fw_retain_cfg | core_low_s;
        end else begin
            case (state_q)
                RRC_ST_RUN: begin
                    if (sleep_req) begin
                        state_d = RRC_ST_SLEEP;
                        event_d = RRC_EV_SLEEP;
                        oth_d = 1'b1;
                        fw_d = 1'b1;
                    end
                end
                RRC_ST_RESET: begin
                    // Stretch each reset so downstream logic sees a clean pulse
                    if (cnt_q > 4'h1) begin
                        cnt_d = cnt_q - 4'h1;
                        ao_d = ao_q;
                        oth_d = oth_q;
                        seq_d = seq_q;
                        fw_d = fw_q;
                    end else begin
                        cnt_d = 4'h0;
                        // Regulator already off: go straight to sleep with its clears
                        if (sleep_req) begin
                            state_d = RRC_ST_SLEEP;
                            event_d = RRC_EV_SLEEP;
                            oth_d = 1'b1;
                            fw_d = 1'b1;
                        end else begin
                            state_d = RRC_ST_RUN;
                        end
                    end
                end
                RRC_ST_SLEEP: begin
                    // Other registers and firmware held clear for all of sleep
                    oth_d = 1'b1;
                    fw_d = 1'b1;
                    if (!sleep_req) begin
                        state_d = RRC_ST_RESET;
                        // Short settle; retained groups are not pulsed again
                        cnt_d = `RRC_SLEEP_EXIT_CYCLES;
                    end
                end
                // Unused encodings fall back to run
                default: state_d = RRC_ST_RUN;
            endcase
        end
    end

    // Registers only; reset state is a full power-on clear
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= RRC_ST_RESET;
            event_q <= RRC_EV_POR;
            cnt_q <= `RRC_PULSE_CYCLES;
            ao_q <= 1'b1;
            oth_q <= 1'b1;
            seq_q <= 1'b1;
            fw_q <= 1'b1;
        end else begin
            state_q <= state_d;
            event_q <= event_d;
            cnt_q <= cnt_d;
            ao_q <= ao_d;
            oth_q <= oth_d;
            seq_q <= seq_d;
            fw_q <= fw_d;
        end
    end

    assign clear_always_on = ao_q;
    assign clear_other_regs = oth_q;
    assign clear_sequencer_mem = seq_q;
    assign clear_fw_mem = fw_q;
    assign core_regulator_on = regulator_on;
    assign sleep_active = (state_q == RRC_ST_SLEEP);
    assign last_event = event_q;
endmodule : rrc_reset_ctrl

// file: rrc_reset_ctrl_asserts.sv
// Port checker for the reset and retention controller
`timescale 1ns/1ps
module rrc_reset_ctrl_asserts
    import rrc_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic core_regulator_enable_bit,
    input wire logic reg_write,
    input wire logic [15:0] reg_write_addr,
    input wire logic clear_always_on,
    input wire logic clear_other_regs,
    input wire logic clear_sequencer_mem,
    input wire logic clear_fw_mem,
    input wire logic core_regulator_on,
    input wire logic sleep_active,
    input wire rrc_event_t last_event
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Write to address zero, whatever the data
    sw_clear_a: assert property (reg_write && reg_write_addr == 16'h0000
        |=> clear_always_on && clear_other_regs) else $error("sw reset missed");
    sw_event_a: assert property (reg_write && reg_write_addr == 16'h0000
        && !clear_always_on |=> last_event == RRC_EV_SW) else $error("sw event wrong");
    por_all_a: assert property (last_event == RRC_EV_POR && clear_always_on |->
        clear_other_regs && clear_sequencer_mem && clear_fw_mem) else $error("por partial");
    hw_keep_a: assert property (last_event == RRC_EV_HW && clear_always_on |->
        clear_other_regs && !clear_sequencer_mem) else $error("hw groups wrong");
    seq_por_a: assert property (clear_sequencer_mem |->
        last_event == RRC_EV_POR) else $error("sequencer cleared");
    // Sleep keeps always-on and sequencer
    sleep_keep_a: assert property (sleep_active |-> !clear_always_on &&
        !clear_sequencer_mem && clear_other_regs && clear_fw_mem) else $error("sleep groups");
    sleep_cause_a: assert property ($rose(sleep_active) |->
        !$past(core_regulator_on)) else $error("sleep with regulator on");
    reg_or_a: assert property (core_regulator_enable_bit |->
        core_regulator_on) else $error("regulator off");
    stretch_a: assert property ($rose(clear_always_on) |->
        clear_always_on [*4]) else $error("pulse short");
endmodule : rrc_reset_ctrl_asserts

// file: rrc_host_model.sv
// Host and power manager driving pins and supplies
`timescale 1ns/1ps
module rrc_host_model (
    input wire logic clk,
    output logic pin_n,
    output logic reg_pin,
    output logic [1:0] sup_low,
    output logic core_low
);
    // Regulator pin up before any reset keeps core supply
    initial begin
        pin_n = 1'h1;
        reg_pin = 1'h1;
        sup_low = 2'h0;
        core_low = 1'h0;
    end
    task automatic hw(input int n);
        @(negedge clk) pin_n = 1'h0;
        repeat (n) @(negedge clk);
        pin_n = 1'h1;
    endtask : hw
    // Other supplies stay present while the pin is low
    task automatic slp(input logic on);
        @(negedge clk) reg_pin = !on;
    endtask : slp
    task automatic dip(input logic [1:0] m, input int n);
        @(negedge clk) sup_low = m;
        repeat (n) @(negedge clk);
        sup_low = 2'h0;
    endtask : dip
    // Core dip outside sleep, only when a scenario asks
    task automatic core(input logic v);
        @(negedge clk) core_low = v;
    endtask : core
endmodule : rrc_host_model

// file: tb_rrc_reset_ctrl.sv
// Testbench for the reset and retention controller
`timescale 1ns/1ps
module tb_rrc_reset_ctrl;
    import rrc_pkg::*;
    logic core_clk, resetn, reg_write, reg_bit, retain;
    logic [15:0] addr;
    wire pin_n, reg_pin, core_low, sleep_active, core_regulator_on;
    wire [1:0] sup;
    wire [3:0] cl;
    rrc_event_t last_event;
    int miscompares = 0;
    int num_checks = 0;
    int cyc = 0;
    rrc_host_model host (.clk(core_clk), .pin_n(pin_n), .reg_pin(reg_pin), .sup_low(sup),
        .core_low(core_low));
    rrc_reset_ctrl DUT (.core_clk(core_clk), .resetn(resetn), .analog_supply_low(sup[0]),
        .primary_io_supply_low(sup[1]), .core_supply_low(core_low), .reset_pin_n(pin_n),
        .core_regulator_enable_pin(reg_pin), .core_regulator_enable_bit(reg_bit),
        .reg_write(reg_write), .reg_write_addr(addr), .fw_retain_cfg(retain),
        .clear_always_on(cl[3]), .clear_other_regs(cl[2]), .clear_sequencer_mem(cl[1]),
        .clear_fw_mem(cl[0]), .core_regulator_on(core_regulator_on),
        .sleep_active(sleep_active), .last_event(last_event));
    initial begin
        core_clk = 1'h0;
        forever #4 core_clk = ~core_clk;
    end
    // Hang guard, well above the scenario length
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up
    // Clears, sleep and regulator state against expectation
    task automatic chk(input logic [5:0] x, input rrc_event_t e);
        num_checks++;
        if ({cl, sleep_active, core_regulator_on} !== x || last_event !== e) begin
            miscompares++;
            $display("mismatch at %0t: got %h event %0d", $time, cl, last_event);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a);
        @(negedge core_clk) reg_write = 1'h1;
        addr = a;
        @(negedge core_clk) reg_write = 1'h0;
    endtask : wr
    task automatic t_por();
        host.dip(2'h1, 4);
        chk({4'hF, 2'h1}, RRC_EV_POR);
        repeat (10) @(negedge core_clk);
        host.dip(2'h2, 4);
        chk({4'hF, 2'h1}, RRC_EV_POR);
        repeat (10) @(negedge core_clk);
    endtask : t_por
    // Second write to address zero restarts the stretch
    task automatic t_sw();
        wr(16'h0001);
        chk({4'h0, 2'h1}, RRC_EV_POR);
        wr(16'h0000);
        chk({4'hC, 2'h1}, RRC_EV_SW);
        repeat (2) @(negedge core_clk);
        wr(16'h0000);
        repeat (3) @(negedge core_clk);
        chk({4'hC, 2'h1}, RRC_EV_SW);
        repeat (8) @(negedge core_clk);
        retain = 1'h0;
        wr(16'h0000);
        chk({4'hD, 2'h1}, RRC_EV_SW);
        repeat (8) @(negedge core_clk);
    endtask : t_sw
    task automatic t_hw();
        retain = 1'h1;
        host.core(1'h1);
        host.hw(5);
        chk({4'hD, 2'h1}, RRC_EV_HW);
        host.core(1'h0);
        repeat (12) @(negedge core_clk);
        host.hw(5);
        chk({4'hC, 2'h1}, RRC_EV_HW);
        repeat (12) @(negedge core_clk);
    endtask : t_hw
    // Bit alone low is not sleep
    task automatic t_slp();
        reg_bit = 1'h0;
        repeat (6) @(negedge core_clk);
        chk({4'h0, 2'h1}, RRC_EV_HW);
        host.slp(1'h1);
        repeat (6) @(negedge core_clk);
        chk({4'h5, 2'h2}, RRC_EV_SLEEP);
        host.slp(1'h0);
        repeat (6) @(negedge core_clk);
        chk({4'h0, 2'h1}, RRC_EV_SLEEP);
        // Pin low with bit high keeps the regulator on
        reg_bit = 1'h1;
        host.slp(1'h1);
        repeat (6) @(negedge core_clk);
        chk({4'h0, 2'h1}, RRC_EV_SLEEP);
        reg_bit = 1'h0;
        repeat (6) @(negedge core_clk);
        chk({4'h5, 2'h2}, RRC_EV_SLEEP);
        // Mid-run reset while asleep, then straight back into sleep
        resetn = 1'h0;
        repeat (2) @(negedge core_clk);
        chk({4'hF, 2'h0}, RRC_EV_POR);
        resetn = 1'h1;
        repeat (8) @(negedge core_clk);
        chk({4'h5, 2'h2}, RRC_EV_SLEEP);
        reg_bit = 1'h1;
        repeat (6) @(negedge core_clk);
        chk({4'h0, 2'h1}, RRC_EV_SLEEP);
    endtask : t_slp
    initial begin
        resetn = 1'h0;
        reg_write = 1'h0;
        addr = 16'h0000;
        reg_bit = 1'h1;
        retain = 1'h1;
        repeat (6) @(negedge core_clk);
        chk({4'hF, 2'h1}, RRC_EV_POR);
        resetn = 1'h1;
        t_por();
        t_sw();
        t_hw();
        t_slp();
        wrap_up();
    end
endmodule : tb_rrc_reset_ctrl
bind rrc_reset_ctrl rrc_reset_ctrl_asserts u_chk (.core_clk(core_clk), .resetn(resetn),
    .core_regulator_enable_bit(core_regulator_enable_bit), .reg_write(reg_write),
    .reg_write_addr(reg_write_addr), .clear_always_on(clear_always_on),
    .clear_other_regs(clear_other_regs), .clear_sequencer_mem(clear_sequencer_mem),
    .clear_fw_mem(clear_fw_mem), .core_regulator_on(core_regulator_on),
    .sleep_active(sleep_active), .last_event(last_event));
